// [shared/vafr_params.svh]
// offsets, field positions and reset values of the video alpha / fifo request register slice
`ifndef VAFR_PARAMS_SVH
`define VAFR_PARAMS_SVH

`define VAFR_OFS_W3_SETUP      12'h08C
`define VAFR_OFS_FETCH_POS     12'h090
`define VAFR_OFS_ALPHA_RB      12'h094
`define VAFR_OFS_MODE_STAT     12'h400

`define VAFR_W3_LEVEL_LSB      0
`define VAFR_W3_STEP_LSB       8
`define VAFR_W3_STEP_SIGN      15
`define VAFR_W3_ON_BIT         16
`define VAFR_W3_RELOAD_BIT     17

`define VAFR_COL_LSB           16
`define VAFR_COL_MSB           27
`define VAFR_LINE_LSB          0
`define VAFR_LINE_MSB          10

`define VAFR_RB_W3_LSB         16
`define VAFR_RB_W2_LSB         8
`define VAFR_RB_W1_LSB         0

`define VAFR_UNDERFLOW_BIT     31
`define VAFR_OVERFLOW_BIT      30

`define VAFR_FETCH_POS_RESET   32'h001B0017
`define VAFR_W3_SETUP_RESET    32'h00000000
`define VAFR_ALPHA_MAX         8'hFF
`define VAFR_ALPHA_MIN         8'h00

`endif

// [shared/vafr_pkg.sv]
// types shared by the video alpha / fifo request register slice
package vafr_pkg;
    typedef logic [7:0]  vafr_alpha_t;
    typedef logic [11:0] vafr_col_t;
    typedef logic [10:0] vafr_line_t;
    typedef logic [31:0] vafr_word_t;
endpackage

// [core/vafr_regs.sv]
// register slice: window-3 alpha ramp, fifo fetch position, alpha readback, fifo flags
// Summary of operation
// (RL1) Each frame the signed window-3 step, sign in its top bit, is added to the window-3 alpha level.
// (RL2) Once the ramped level reaches 255 or 0 it stays there on later frames until a reload.
// (RL3) The 8-bit window-3 level in the low byte of the setup register is the blending alpha source.
// (RL4) Window-3 alpha is only in effect while the video window enable input is high.
// (RL5) Fetching from the video fifo starts at the pixel column held in the 12-bit start column field.
// (RL6) Software programs the start column as screen position plus line length minus sync stop, minus two.
// (RL7) Fetching from the video fifo starts on the line held in the 11-bit start line field.
// (RL8) Software programs the start line as screen line plus frame length minus sync stop line, plus one.
// (RL9) Software writes zero into the top four reserved bits of the fetch position register.
// (RL10) The read-only readback gives window 3, 2 and 1 alpha in bits 23:16, 15:8 and 7:0.
// (RL11) Bit 31 of the mode/status register is set on fifo underflow and stays set until cleared.
// (RL12) Writing one to the underflow flag clears it and writing zero leaves it.
// (RL13) Bit 30 of the mode/status register is set on fifo overflow and stays set until cleared.
// (RL14) The overflow flag stays set until a one is written to it; a zero has no effect.
// (RL15) Writing one to the reload strobe loads the programmed window-3 level at the next frame start.
// (RL16) Bit 16 of the setup register enables alpha window 3.
`include "vafr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module vafr_regs
    import vafr_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic [11:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    input  wire logic        FRAME_START,
    input  wire logic        VIDEO_WIN_EN,
    input  wire logic [11:0] H_POS,
    input  wire logic [10:0] V_POS,
    input  wire logic [7:0]  ALPHA_W1_LEVEL,
    input  wire logic [7:0]  ALPHA_W2_LEVEL,
    input  wire logic        FIFO_UNDERFLOW,
    input  wire logic        FIFO_OVERFLOW,
    output logic      [7:0]  ALPHA_W3,
    output logic             ALPHA_W3_ACTIVE,
    output logic             FIFO_FETCH_GO
);

    // saturating signed add; second result says a limit was hit
    function automatic logic [8:0] ramp_step(input vafr_alpha_t lvl, input logic [7:0] stp);
        logic [9:0] sum;
        sum = {2'b00, lvl} + {{2{stp[7]}}, stp};
        if (sum[9])
            ramp_step = {1'b1, `VAFR_ALPHA_MIN};
        else if (sum[8])
            ramp_step = {1'b1, `VAFR_ALPHA_MAX};
        else
            ramp_step = {(sum[7:0] == `VAFR_ALPHA_MAX) || (sum[7:0] == `VAFR_ALPHA_MIN), sum[7:0]};
    endfunction

    function automatic logic is_wr(input logic [11:0] a, input logic [11:0] ofs, input logic w);
        is_wr = w && (a == ofs);
    endfunction

    vafr_alpha_t prog_level_reg, prog_level_next;
    logic [7:0]  step_reg,       step_next;
    logic        w3_on_reg,      w3_on_next;
    logic        reload_reg,     reload_next;
    vafr_alpha_t cur_level_reg,  cur_level_next;
    logic        held_reg,       held_next;
    vafr_col_t   col_reg,        col_next;
    vafr_line_t  line_reg,       line_next;
    logic        under_reg,      under_next;
    logic        over_reg,       over_next;
    logic        go_reg,         go_next;
    vafr_word_t  rdata_reg,      rdata_next;
    logic [8:0]  ramp;

    // setup register writes and the per-frame ramp
    always_comb
    begin
        prog_level_next = prog_level_reg;
        step_next       = step_reg;
        w3_on_next      = w3_on_reg;
        reload_next     = reload_reg;
        cur_level_next  = cur_level_reg;
        held_next       = held_reg;
        ramp            = ramp_step(cur_level_reg, step_reg);  // [RL1]
        if (FRAME_START)
        begin
            if (reload_reg)
            begin
                cur_level_next = prog_level_reg;              // [RL15]
                held_next      = 1'b0;
                reload_next    = 1'b0;
            end
            else if (!held_reg)
            begin
                cur_level_next = ramp[7:0];                   // [RL1]
                held_next      = ramp[8];                     // [RL2]
            end
        end
        // a strobe in the frame-start cycle waits for the next frame
        if (is_wr(REG_ADDR, `VAFR_OFS_W3_SETUP, REG_WR))
        begin
            prog_level_next = REG_WDATA[`VAFR_W3_LEVEL_LSB +: 8];   // [RL3]
            step_next       = REG_WDATA[`VAFR_W3_STEP_LSB +: 8];
            w3_on_next      = REG_WDATA[`VAFR_W3_ON_BIT];           // [RL16]
            if (REG_WDATA[`VAFR_W3_RELOAD_BIT])
                reload_next = 1'b1;                                 // [RL15]
        end
    end

    // fetch position, flags, fetch trigger and read data
    always_comb
    begin
        col_next   = col_reg;
        line_next  = line_reg;
        under_next = under_reg;
        over_next  = over_reg;
        rdata_next = rdata_reg;
        if (is_wr(REG_ADDR, `VAFR_OFS_FETCH_POS, REG_WR))
        begin
            // reserved bits are dropped, so they read zero whatever is written
            col_next  = REG_WDATA[`VAFR_COL_MSB:`VAFR_COL_LSB];      // [RL5] [RL9]
            line_next = REG_WDATA[`VAFR_LINE_MSB:`VAFR_LINE_LSB];    // [RL7]
        end
        if (is_wr(REG_ADDR, `VAFR_OFS_MODE_STAT, REG_WR))
        begin
            if (REG_WDATA[`VAFR_UNDERFLOW_BIT])
                under_next = 1'b0;                                   // [RL12]
            if (REG_WDATA[`VAFR_OVERFLOW_BIT])
                over_next = 1'b0;                                    // [RL14]
        end
        // set after clear so a same-cycle event survives
        if (FIFO_UNDERFLOW)
            under_next = 1'b1;                                       // [RL11]
        if (FIFO_OVERFLOW)
            over_next = 1'b1;                                        // [RL13]
        // position is software's job; this only compares
        go_next = (H_POS == col_reg) && (V_POS == line_reg);         // [RL5] [RL6] [RL7] [RL8]
        if (REG_RD)
        begin
            if (REG_ADDR == `VAFR_OFS_W3_SETUP)
                rdata_next = {15'h0000, w3_on_reg, step_reg, prog_level_reg};
            else if (REG_ADDR == `VAFR_OFS_FETCH_POS)
                rdata_next = {4'h0, col_reg, 5'h00, line_reg};
            else if (REG_ADDR == `VAFR_OFS_ALPHA_RB)
                rdata_next = {8'h00, cur_level_reg, ALPHA_W2_LEVEL, ALPHA_W1_LEVEL};  // [RL10]
            else if (REG_ADDR == `VAFR_OFS_MODE_STAT)
                rdata_next = {under_reg, over_reg, 30'h00000000};
            else
                rdata_next = 32'h00000000;
        end
    end

    // state registers, synchronous reset
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            prog_level_reg <= 8'h00;
            step_reg       <= 8'h00;
            w3_on_reg      <= 1'b0;
            reload_reg     <= 1'b0;
            cur_level_reg  <= 8'h00;
            held_reg       <= 1'b0;
            col_reg        <= 12'h01B;
            line_reg       <= 11'h017;
            under_reg      <= 1'b0;
            over_reg       <= 1'b0;
            go_reg         <= 1'b0;
            rdata_reg      <= 32'h00000000;
        end
        else
        begin
            prog_level_reg <= prog_level_next;
            step_reg       <= step_next;
            w3_on_reg      <= w3_on_next;
            reload_reg     <= reload_next;
            cur_level_reg  <= cur_level_next;
            held_reg       <= held_next;
            col_reg        <= col_next;
            line_reg       <= line_next;
            under_reg      <= under_next;
            over_reg       <= over_next;
            go_reg         <= go_next;
            rdata_reg      <= rdata_next;
        end
    end

    assign REG_RDATA       = rdata_reg;
    assign ALPHA_W3        = cur_level_reg;                          // [RL3]
    assign ALPHA_W3_ACTIVE = w3_on_reg && VIDEO_WIN_EN;              // [RL4] [RL16]
    assign FIFO_FETCH_GO   = go_reg;

    sequence s_strobe_w;
        is_wr(REG_ADDR, `VAFR_OFS_W3_SETUP, REG_WR) && REG_WDATA[`VAFR_W3_RELOAD_BIT] && !FRAME_START;
    endsequence

    // a pending reload meets a frame start: the programmed level is due next
    sequence s_reload_frame;
        reload_reg && FRAME_START;
    endsequence

    AST_RAMP_ADD: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL1]
        FRAME_START && !reload_reg && !held_reg |=>
            held_reg || (cur_level_reg == $past(cur_level_reg) + $past(step_reg)))
        else $error("ramp step not applied");

    AST_HOLD_LIMIT: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL2]
        held_reg && !reload_reg |=> $stable(cur_level_reg))
        else $error("held alpha moved");

    AST_LIMIT_HOLDS: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL2]
        FRAME_START && !reload_reg && !held_reg && ramp[8] |=> held_reg && (cur_level_reg == 8'hFF || cur_level_reg == 8'h00))
        else $error("limit not latched");

    AST_RELOAD_PEND: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL15]
        s_strobe_w |=> reload_reg)
        else $error("reload strobe not held pending");

    AST_RELOAD_LOAD: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL15]
        s_reload_frame |=> cur_level_reg == $past(prog_level_reg) && !reload_reg && !held_reg)
        else $error("reload not taken at frame start");

    AST_ACTIVE: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL4]
        !VIDEO_WIN_EN |-> !ALPHA_W3_ACTIVE)
        else $error("window 3 active without video window");

    AST_ENABLE: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL16]
        is_wr(REG_ADDR, `VAFR_OFS_W3_SETUP, REG_WR) && VIDEO_WIN_EN ##1 VIDEO_WIN_EN |-> ALPHA_W3_ACTIVE == $past(REG_WDATA[16]))
        else $error("enable bit not followed");

    AST_FETCH_GO: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL5] [RL7]
        (H_POS == col_reg) && (V_POS == line_reg) && !REG_WR |=> FIFO_FETCH_GO)
        else $error("fetch not started at position");

    AST_READBACK: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL10]
        REG_RD && REG_ADDR == `VAFR_OFS_ALPHA_RB |=> REG_RDATA == {8'h00, $past(cur_level_reg), $past(ALPHA_W2_LEVEL), $past(ALPHA_W1_LEVEL)})
        else $error("alpha readback wrong");

    AST_UNDER_STICKY: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL11] [RL12]
        under_reg && !(is_wr(REG_ADDR, `VAFR_OFS_MODE_STAT, REG_WR) && REG_WDATA[31]) |=> under_reg)
        else $error("underflow flag lost");

    AST_UNDER_CLEAR: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL12]
        is_wr(REG_ADDR, `VAFR_OFS_MODE_STAT, REG_WR) && REG_WDATA[31] && !FIFO_UNDERFLOW |=> !under_reg)
        else $error("underflow flag not cleared");

    AST_OVER_SET: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL13]
        FIFO_OVERFLOW |=> over_reg)
        else $error("overflow flag not set");

    AST_OVER_READ: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL13]
        REG_RD && REG_ADDR == `VAFR_OFS_MODE_STAT |=> REG_RDATA[`VAFR_OVERFLOW_BIT] == $past(over_reg))
        else $error("overflow flag read back wrong");

    AST_OVER_CLEAR: assert property (@(posedge SYS_CLK) disable iff (RST) // [RL14]
        is_wr(REG_ADDR, `VAFR_OFS_MODE_STAT, REG_WR) && REG_WDATA[30] && !FIFO_OVERFLOW |=> !over_reg)
        else $error("overflow flag not cleared");

endmodule

`default_nettype wire

// [sim/vafr_regs_tb_top.sv]
// self-checking bench for the video alpha / fifo request register slice
`timescale 1ns/1ps
`default_nettype none

module vafr_regs_tb_top
    import vafr_pkg::*;
;
    typedef struct packed {logic w; logic [11:0] a; vafr_word_t d;} vafr_row_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr  = 1'b0;
    logic        rd  = 1'b0;
    logic        fs  = 1'b0;
    logic        wen = 1'b0;
    logic        unf = 1'b0;
    logic        ovf = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [11:0] hp = 12'h000;
    logic [10:0] vp = 11'h000;
    logic [7:0]  w1 = 8'h12;
    logic [7:0]  w2 = 8'h34;
    vafr_word_t  wd = 32'h00000000;
    vafr_word_t  rdata;
    vafr_word_t  m;
    vafr_alpha_t a3;
    logic        act;
    logic        go;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          i;

    // plain register traffic: reset-value reads, then write rows, each with the read that must follow
    vafr_row_t rows [11] = '{
        '{1'b0, 12'h090, 32'h001B0017},
        '{1'b0, 12'h094, 32'h00003412},
        '{1'b0, 12'h400, 32'h00000000},
        '{1'b1, 12'h090, 32'h0FFFFFFF}, // top nibble left zero
        '{1'b0, 12'h090, 32'h0FFF07FF},
        '{1'b1, 12'h094, 32'hFFFFFFFF},
        '{1'b0, 12'h094, 32'h00003412},
        '{1'b1, 12'h098, 32'hFFFFFFFF},
        '{1'b0, 12'h098, 32'h00000000},
        '{1'b1, 12'h08C, 32'h00030A10},
        '{1'b0, 12'h08C, 32'h00010A10}
    };

    always #2.5 clk = ~clk;

    vafr_regs dut (
        .SYS_CLK        (clk),
        .RST            (rst),
        .REG_ADDR       (addr),
        .REG_WR         (wr),
        .REG_RD         (rd),
        .REG_WDATA      (wd),
        .REG_RDATA      (rdata),
        .FRAME_START    (fs),
        .VIDEO_WIN_EN   (wen),
        .H_POS          (hp),
        .V_POS          (vp),
        .ALPHA_W1_LEVEL (w1),
        .ALPHA_W2_LEVEL (w2),
        .FIFO_UNDERFLOW (unf),
        .FIFO_OVERFLOW  (ovf),
        .ALPHA_W3       (a3),
        .ALPHA_W3_ACTIVE(act),
        .FIFO_FETCH_GO  (go)
    );

    task automatic chk(input vafr_word_t seen, input vafr_word_t exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // strobes are raised on one falling edge and dropped on the next
    task automatic reg_wr(input logic [11:0] a, input vafr_word_t d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wd = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // read data lands one edge after the strobe, so it is settled here
    task automatic reg_rd(input logic [11:0] a, input vafr_word_t e);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, e);
    endtask

    task automatic frame(input int n);
        repeat (n)
        begin
            @(negedge clk);
            fs = 1'b1;
            @(negedge clk);
            fs = 1'b0;
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        foreach (rows[k])
        begin
            if (rows[k].w)
                reg_wr(rows[k].a, rows[k].d);
            else
                reg_rd(rows[k].a, rows[k].d);
        end
        // ramp up from the reloaded level until it pins at the top
        frame(1);
        chk(32'(a3), 32'h00000010);
        frame(1);
        chk(32'(a3), 32'h0000001A);
        frame(24);
        chk(32'(a3), 32'h000000FF);
        // negative step, reload, then pin at zero exactly
        reg_wr(12'h08C, 32'h0002F080);
        frame(1);
        chk(32'(a3), 32'h00000080);
        frame(1);
        chk(32'(a3), 32'h00000070);
        reg_rd(12'h094, 32'h00703412);
        w1 = 8'hC3;
        w2 = 8'h5A;
        reg_rd(12'h094, 32'h00705AC3);
        frame(7);
        chk(32'(a3), 32'h00000000);
        reg_wr(12'h08C, 32'h00000500);
        frame(2);
        chk(32'(a3), 32'h00000000);
        // window enable gated by the video window enable
        for (i = 0; i < 4; i++)
        begin
            reg_wr(12'h08C, {15'h0000, i[1], 16'h0500});
            wen = i[0];
            @(negedge clk);
            chk({31'h0, act}, {31'h0, i[0] & i[1]});
        end
        // fetch position worked out the way software is told to
        reg_wr(12'h090, {4'h0, 12'd100 + 12'd800 - 12'd752 - 12'd2, 5'h00, 11'd20 + 11'd525 - 11'd492 + 11'd1});
        hp = 12'd146;
        vp = 11'd54;
        @(negedge clk);
        chk({31'h0, go}, 32'h00000001);
        hp = 12'd147;
        @(negedge clk);
        chk({31'h0, go}, 32'h00000000);
        hp = 12'd146;
        vp = 11'd55;
        @(negedge clk);
        chk({31'h0, go}, 32'h00000000);
        vp = 11'd0;
        // sticky flags: zero write keeps, one write clears
        for (i = 0; i < 2; i++)
        begin
            m = 32'h80000000 >> i;
            @(negedge clk);
            unf = (i == 0);
            ovf = (i == 1);
            @(negedge clk);
            unf = 1'b0;
            ovf = 1'b0;
            reg_rd(12'h400, m);
            reg_wr(12'h400, 32'h00000000);
            reg_rd(12'h400, m);
            reg_wr(12'h400, m);
            reg_rd(12'h400, 32'h00000000);
        end
        // event in the clearing cycle: the set must win
        @(negedge clk);
        unf  = 1'b1;
        wr   = 1'b1;
        addr = 12'h400;
        wd   = 32'h80000000;
        @(negedge clk);
        unf = 1'b0;
        wr  = 1'b0;
        reg_rd(12'h400, 32'h80000000);
        reg_wr(12'h400, 32'h80000000);
        reg_rd(12'h400, 32'h00000000);
        // second reset in mid-run brings back the documented values
        reg_wr(12'h08C, 32'h00020055);
        frame(1);
        chk(32'(a3), 32'h00000055);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(32'(a3), 32'h00000000);
        chk(rdata, 32'h00000000);
        chk({31'h0, act}, 32'h00000000);
        chk({31'h0, go}, 32'h00000000);
        reg_rd(12'h090, 32'h001B0017);
        print_verdict();
    end
endmodule

`default_nettype wire
